// file: stw_pkg.sv
package stw_pkg;
   // ---------------------------------------------------------------
   // Register addresses
   // ---------------------------------------------------------------
   localparam logic [7:0] ADDR_SWRST = 8'hF7;
   localparam logic [7:0] ADDR_EIPRI = 8'hF8;
   localparam logic [7:0] ADDR_SECIRQ = 8'hF9;
   localparam logic [7:0] ADDR_MSIRQ = 8'hFA;
   localparam logic [7:0] ADDR_MICROSECOND_RELOAD = 8'hFB;
   localparam logic [7:0] ADDR_MSL = 8'hFC;
   localparam logic [7:0] ADDR_MSH = 8'hFD;
   localparam logic [7:0] ADDR_HMS = 8'hFE;
   localparam logic [7:0] ADDR_WDCTL = 8'hFF;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int SWRST_BIT = 0;
   localparam int LOAD_NOW_BIT = 7;
   localparam int WD_EN_BIT = 7;
   localparam int WD_DIS_BIT = 6;
   localparam int WD_RST_BIT = 5;
   localparam int WD_CNT_W = 5;
   localparam int EIP_W = 5;
   // ---------------------------------------------------------------
   // Values after reset
   // ---------------------------------------------------------------
   localparam logic [7:0] MICROSECOND_RELOAD_RST = 8'h63;
   localparam logic [15:0] MILLISECOND_RELOAD_VALUE_RST = 16'h03E7;
   localparam logic [7:0] HMS_RST = 8'h63;
   localparam logic [6:0] SEC_RST = 7'h09;
   localparam logic [6:0] MSI_RST = 7'h00;
   localparam logic [4:0] WD_CNT_RST = 5'h1F;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int POWERUP_NS = 1000;
   localparam int POWERUP_CYC = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RST_HOLD_CYC = 16;
endpackage

// file: stw_down_cnt.sv
// Reloadable down-counter: one output tick per (reload_val + 1) steps.
module stw_down_cnt #(
   parameter int W = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic software_reset,
   // Control
   input wire logic step,
   input wire logic load_now,
   input wire logic [W-1:0] reload_val,
   // Result
   output logic tick_o
);
   logic [W-1:0] cnt_r;

   always_ff @(posedge clk_sys) begin
      if (software_reset) begin
         cnt_r <= '0;
      end else if (load_now) begin
         cnt_r <= reload_val;
      end else if (step) begin
         if (cnt_r == '0) begin
            cnt_r <= reload_val;
         end else begin
            cnt_r <= cnt_r - 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (software_reset) begin
         tick_o <= 1'b0;
      end else begin
         tick_o <= step && !load_now && (cnt_r == '0);
      end
   end
endmodule

// file: stw_timebase.sv
// Overview of operation
// (R1) Writing bit 0 of software reset high then low resets the whole device.
// (R2) After that reset, straps are sampled only once the power-up delay elapsed.
// (R3) Microsecond counter ticks every reload+1 clocks, reloading at zero.
// (R4) Millisecond reload is high*256+low; ticks every value+1 clocks.
// (R5) Hundred-ms counter steps on ms ticks, period reload+1 ms periods.
// (R6) Seconds counter steps on hundred-ms ticks, period reload+1 of them.
// (R7) Seconds reload write with bit 7 loads at once, else at expiry.
// (R8) Ms interrupt counter steps on ms ticks, period reload+1 of them.
// (R9) Ms interrupt reload write with bit 7 loads at once, else at expiry.
// (R10) Seconds interrupt raised only when its enable is set.
// (R11) Ms interrupt raised only when its enable is set.
// (R12) Watchdog expires count+1 to count+2 hundred-ms periods after start.
// (R13) Bits 7/6/5 written 1 then 0 enable/disable/restart; one write does nothing.
// (R14) Watchdog at zero resets, or interrupts when reset disable is set.
// (R15) Software must keep restarting the enabled watchdog before it expires.
// (R16) Priority register holds five bits: watchdog and four external interrupts.
// (R17) Watchdog loads on enable or restart and steps on hundred-ms ticks.
module stw_timebase (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic software_reset,
   // Register port
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   // Enables from other blocks
   input wire logic seconds_irq_enable,
   input wire logic millisecond_reload_value_irq_enable,
   input wire logic watchdog_reset_disable,
   // Strap pins
   input wire logic ale_strap,
   input wire logic program_store_strap,
   input wire logic external_access_strap,
   // Results
   output logic sys_reset_out,
   output logic straps_valid,
   output logic [2:0] straps_captured,
   output logic seconds_irq,
   output logic millisecond_reload_value_irq,
   output logic watchdog_irq,
   output logic [4:0] ext_irq_priority
);
   // ---------------------------------------------------------------
   // Reset generation
   // ---------------------------------------------------------------
   logic blk_rst;
   logic soft_rst_req;
   logic wd_timeout;
   logic [7:0] hold_r;
   logic [15:0] pwr_r;
   logic [2:0] strap_s1_r, strap_s2_r, strap_s3_r, strap_f_r;

   assign blk_rst = software_reset | sys_reset_out;

   always_ff @(posedge clk_sys) begin
      if (software_reset) begin
         hold_r <= 8'h00;
         sys_reset_out <= 1'b1;
      end else if (soft_rst_req || (wd_timeout && !watchdog_reset_disable)) begin // R1 R14
         hold_r <= 8'(stw_pkg::RST_HOLD_CYC - 1);
         sys_reset_out <= 1'b1;
      end else if (hold_r != 8'h00) begin
         hold_r <= hold_r - 8'h01;
      end else begin
         sys_reset_out <= 1'b0;
      end
   end

   always_ff @(posedge clk_sys) begin
      strap_s1_r <= {ale_strap, program_store_strap, external_access_strap};
      strap_s2_r <= strap_s1_r;
      strap_s3_r <= strap_s2_r;
      if (software_reset) begin
         strap_f_r <= 3'h0;
      end else if (strap_s2_r == strap_s3_r) begin
         strap_f_r <= strap_s3_r;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         pwr_r <= 16'h0000;
         straps_valid <= 1'b0;
         straps_captured <= 3'h0;
      end else if (!straps_valid) begin
         if (pwr_r == 16'(stw_pkg::POWERUP_CYC - 1)) begin // R2
            straps_valid <= 1'b1;
            straps_captured <= strap_f_r;
         end else begin
            pwr_r <= pwr_r + 16'h0001;
         end
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic wr_swrst, wr_sec, wr_msi, wr_wd;
   logic swrst_r;
   logic [7:0] microsecond_reload_r, hms_r;
   logic [15:0] millisecond_reload_value_r;
   logic [6:0] sec_r, msi_r;
   logic [4:0] wd_cnt_r;
   logic [2:0] wd_arm_r;

   assign wr_swrst = sfr_wr && (sfr_addr == stw_pkg::ADDR_SWRST);
   assign wr_sec = sfr_wr && (sfr_addr == stw_pkg::ADDR_SECIRQ);
   assign wr_msi = sfr_wr && (sfr_addr == stw_pkg::ADDR_MSIRQ);
   assign wr_wd = sfr_wr && (sfr_addr == stw_pkg::ADDR_WDCTL);
   assign soft_rst_req = wr_swrst && swrst_r && !sfr_wdata[stw_pkg::SWRST_BIT]; // R1

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         swrst_r <= 1'b0;
      end else if (wr_swrst) begin
         swrst_r <= sfr_wdata[stw_pkg::SWRST_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         ext_irq_priority <= 5'h00;
         microsecond_reload_r <= stw_pkg::MICROSECOND_RELOAD_RST;
         millisecond_reload_value_r <= stw_pkg::MILLISECOND_RELOAD_VALUE_RST;
         hms_r <= stw_pkg::HMS_RST;
         sec_r <= stw_pkg::SEC_RST;
         msi_r <= stw_pkg::MSI_RST;
         wd_cnt_r <= stw_pkg::WD_CNT_RST;
      end else if (sfr_wr) begin
         case (sfr_addr)
            stw_pkg::ADDR_EIPRI: ext_irq_priority <= sfr_wdata[stw_pkg::EIP_W-1:0]; // R16
            stw_pkg::ADDR_SECIRQ: sec_r <= sfr_wdata[6:0];
            stw_pkg::ADDR_MSIRQ: msi_r <= sfr_wdata[6:0];
            stw_pkg::ADDR_MICROSECOND_RELOAD: microsecond_reload_r <= sfr_wdata;
            stw_pkg::ADDR_MSL: millisecond_reload_value_r[7:0] <= sfr_wdata; // R4
            stw_pkg::ADDR_MSH: millisecond_reload_value_r[15:8] <= sfr_wdata; // R4
            stw_pkg::ADDR_HMS: hms_r <= sfr_wdata;
            stw_pkg::ADDR_WDCTL: wd_cnt_r <= sfr_wdata[stw_pkg::WD_CNT_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         case (sfr_addr)
            stw_pkg::ADDR_SWRST: sfr_rdata <= {7'h00, swrst_r};
            stw_pkg::ADDR_EIPRI: sfr_rdata <= {3'h0, ext_irq_priority};
            stw_pkg::ADDR_SECIRQ: sfr_rdata <= {1'b0, sec_r};
            stw_pkg::ADDR_MSIRQ: sfr_rdata <= {1'b0, msi_r};
            stw_pkg::ADDR_MICROSECOND_RELOAD: sfr_rdata <= microsecond_reload_r;
            stw_pkg::ADDR_MSL: sfr_rdata <= millisecond_reload_value_r[7:0];
            stw_pkg::ADDR_MSH: sfr_rdata <= millisecond_reload_value_r[15:8];
            stw_pkg::ADDR_HMS: sfr_rdata <= hms_r;
            stw_pkg::ADDR_WDCTL: sfr_rdata <= {wd_arm_r, wd_cnt_r};
            default: sfr_rdata <= 8'h00;
         endcase
      end else begin
         sfr_rdata <= 8'h00;
      end
   end

   // ---------------------------------------------------------------
   // Timebase chain
   // ---------------------------------------------------------------
   logic us_tick, ms_tick, hms_tick, sec_tick, msi_tick;
   logic sec_load, msi_load;

   assign sec_load = wr_sec && sfr_wdata[stw_pkg::LOAD_NOW_BIT]; // R7
   assign msi_load = wr_msi && sfr_wdata[stw_pkg::LOAD_NOW_BIT]; // R9

   stw_down_cnt #(.W(8)) u_microsecond_reload ( // R3
      .clk_sys(clk_sys), .software_reset(blk_rst), .step(1'b1), .load_now(1'b0),
      .reload_val(microsecond_reload_r), .tick_o(us_tick));

   stw_down_cnt #(.W(16)) u_millisecond_reload_value ( // R4
      .clk_sys(clk_sys), .software_reset(blk_rst), .step(1'b1), .load_now(1'b0),
      .reload_val(millisecond_reload_value_r), .tick_o(ms_tick));

   stw_down_cnt #(.W(8)) u_hms ( // R5
      .clk_sys(clk_sys), .software_reset(blk_rst), .step(ms_tick), .load_now(1'b0),
      .reload_val(hms_r), .tick_o(hms_tick));

   stw_down_cnt #(.W(7)) u_sec ( // R6 R7
      .clk_sys(clk_sys), .software_reset(blk_rst), .step(hms_tick), .load_now(sec_load),
      .reload_val(sfr_wdata[6:0] & {7{sec_load}} | sec_r & {7{!sec_load}}), .tick_o(sec_tick));

   stw_down_cnt #(.W(7)) u_msi ( // R8 R9
      .clk_sys(clk_sys), .software_reset(blk_rst), .step(ms_tick), .load_now(msi_load),
      .reload_val(sfr_wdata[6:0] & {7{msi_load}} | msi_r & {7{!msi_load}}), .tick_o(msi_tick));

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         seconds_irq <= 1'b0;
         millisecond_reload_value_irq <= 1'b0;
      end else begin
         seconds_irq <= sec_tick && seconds_irq_enable; // R10
         millisecond_reload_value_irq <= msi_tick && millisecond_reload_value_irq_enable; // R11
      end
   end

   // ---------------------------------------------------------------
   // Watchdog
   // ---------------------------------------------------------------
   logic wd_en_r;
   logic [5:0] wd_down_r;
   logic wd_go_en, wd_go_dis, wd_go_rst;

   // A command fires on the write that clears a bit the previous write set.
   assign wd_go_en = wr_wd && wd_arm_r[2] && !sfr_wdata[stw_pkg::WD_EN_BIT]; // R13
   assign wd_go_dis = wr_wd && wd_arm_r[1] && !sfr_wdata[stw_pkg::WD_DIS_BIT]; // R13
   assign wd_go_rst = wr_wd && wd_arm_r[0] && !sfr_wdata[stw_pkg::WD_RST_BIT]; // R13
   assign wd_timeout = wd_en_r && hms_tick && (wd_down_r == 6'h00) && !wd_go_rst && !wd_go_en;

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         wd_arm_r <= 3'h0;
      end else if (wr_wd) begin
         wd_arm_r <= sfr_wdata[stw_pkg::WD_EN_BIT:stw_pkg::WD_RST_BIT];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         wd_en_r <= 1'b0;
      end else if (wd_go_dis) begin
         wd_en_r <= 1'b0;
      end else if (wd_go_en) begin
         wd_en_r <= 1'b1;
      end
   end

   // Loading count + 1 puts expiry between count + 1 and count + 2 periods.
   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         wd_down_r <= 6'h00;
      end else if (wd_go_en || wd_go_rst) begin
         wd_down_r <= {1'b0, wd_cnt_r} + 6'h01; // R12 R17
      end else if (wd_en_r && hms_tick) begin
         if (wd_down_r == 6'h00) begin
            wd_down_r <= {1'b0, wd_cnt_r} + 6'h01;
         end else begin
            wd_down_r <= wd_down_r - 6'h01; // R17
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (blk_rst) begin
         watchdog_irq <= 1'b0;
      end else begin
         watchdog_irq <= wd_timeout && watchdog_reset_disable; // R14
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (blk_rst);

   sequence swrst_set_s;
      wr_swrst && sfr_wdata[0];
   endsequence
   sequence swrst_clr_s;
      wr_swrst && !sfr_wdata[0];
   endsequence

   // The next three use software_reset alone, since the reset that they check would otherwise cancel them.
   soft_reset_a: assert property (disable iff (software_reset) swrst_r ##0 swrst_clr_s |=> sys_reset_out) // R1
      else $error("software reset sequence did not reset");
   swrst_single_a: assert property (disable iff (software_reset) !blk_rst && !wd_timeout ##0 swrst_set_s // R1
      |=> !sys_reset_out)
      else $error("single software reset write caused a reset");
   wd_reset_a: assert property (disable iff (software_reset) wd_timeout && !watchdog_reset_disable // R14
      |=> sys_reset_out && !watchdog_irq)
      else $error("watchdog timeout did not reset");
   strap_delay_a: assert property ($rose(straps_valid) |-> pwr_r == 16'(stw_pkg::POWERUP_CYC - 1)) // R2
      else $error("straps captured before power-up delay");
   microsecond_reload_period_a: assert property (us_tick && microsecond_reload_r == 8'h02 && $stable(microsecond_reload_r)
      |-> ##1 !us_tick ##1 !us_tick ##1 us_tick) // R3
      else $error("microsecond period wrong");
   ms_gap_a: assert property (ms_tick |=> !ms_tick || millisecond_reload_value_r == 16'h0000) // R4
      else $error("millisecond tick too early");
   hms_step_a: assert property (hms_tick |-> $past(ms_tick)) // R5
      else $error("hundred-ms tick without ms tick");
   sec_step_a: assert property (sec_tick |-> $past(hms_tick)) // R6
      else $error("seconds tick without hundred-ms tick");
   sec_gate_a: assert property (seconds_irq |-> $past(seconds_irq_enable) && $past(sec_tick)) // R10
      else $error("seconds interrupt while disabled");
   msi_gate_a: assert property (millisecond_reload_value_irq |-> $past(millisecond_reload_value_irq_enable) && $past(msi_tick)) // R8 R11
      else $error("ms interrupt while disabled");
   wd_single_a: assert property (wr_wd && !wd_en_r && wd_arm_r == 3'h0 |=> !wd_en_r) // R13
      else $error("watchdog enabled by a single write");
   wd_load_a: assert property (wd_go_rst |=> wd_down_r == {1'b0, $past(wd_cnt_r)} + 6'h01) // R12 R17
      else $error("watchdog restart load wrong");
   wd_mode_a: assert property (wd_timeout && watchdog_reset_disable |=> watchdog_irq && !sys_reset_out) // R14
      else $error("watchdog interrupt mode wrong");
endmodule

// file: stw_testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // Stimulus and observation
   // ---------------------------------------------------------------
   logic clk_sys = 1'b0;
   logic software_reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic en_s = 1'b1;
   logic en_m = 1'b1;
   logic wd_rdis = 1'b1;
   logic [2:0] strap = 3'b000;
   logic sys_reset_out, straps_valid, seconds_irq, millisecond_reload_value_irq, watchdog_irq;
   logic [2:0] straps_captured;
   logic [4:0] ext_irq_priority;
   logic [2:0] irqv;
   logic rd_t = 1'b0;
   logic [7:0] q_rd[$];
   int qlo[3][$];
   int qhi[3][$];
   int cnt[3];
   int npl[3];
   int n_errors = 0;
   int checked = 0;
   assign irqv = {watchdog_irq, seconds_irq, millisecond_reload_value_irq};
   always #5 clk_sys = ~clk_sys;
   stw_timebase DUT (
      .clk_sys(clk_sys),
      .software_reset(software_reset),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata),
      .sfr_rdata(sfr_rdata),
      .seconds_irq_enable(en_s),
      .millisecond_reload_value_irq_enable(en_m),
      .watchdog_reset_disable(wd_rdis),
      .ale_strap(strap[2]),
      .program_store_strap(strap[1]),
      .external_access_strap(strap[0]),
      .sys_reset_out(sys_reset_out),
      .straps_valid(straps_valid),
      .straps_captured(straps_captured),
      .seconds_irq(seconds_irq),
      .millisecond_reload_value_irq(millisecond_reload_value_irq),
      .watchdog_irq(watchdog_irq),
      .ext_irq_priority(ext_irq_priority)
   );
   // ---------------------------------------------------------------
   // Comparison and result watching
   // ---------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      checked++;
      if (g !== e) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rng(input string nm, input int lo, input int hi, input int g);
      checked++;
      if (g < lo || g > hi) begin
         n_errors++;
         $display("CHECK FAILED %s expected %0d to %0d seen %0d", nm, lo, hi, g);
      end
   endtask
   task automatic test_done();
      if (n_errors == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk_sys) rd_t <= sfr_rd;
   // Each interrupt pulse closes an interval; a queued note gives its bounds.
   always @(negedge clk_sys) begin
      if (rd_t) chk("sfr_rdata", q_rd.pop_front(), sfr_rdata);
      for (int i = 0; i < 3; i++) begin
         cnt[i]++;
         if (irqv[i] === 1'b1) begin
            npl[i]++;
            if (qlo[i].size() > 0) rng("irq interval", qlo[i].pop_front(), qhi[i].pop_front(), cnt[i]);
            cnt[i] = 0;
         end
      end
   end
   // ---------------------------------------------------------------
   // Register port and sequences
   // ---------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk_sys);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      q_rd.push_back(e);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge clk_sys);
      sfr_rd = 1'b0;
   endtask
   task automatic expi(input int i, input int lo, input int hi);
      qlo[i].push_back(lo);
      qhi[i].push_back(hi);
   endtask
   task automatic wpulse(input int i);
      int k;
      k = 0;
      do begin @(negedge clk_sys); k++; end while (irqv[i] !== 1'b1 && k < 3000);
      rng("irq wait", 0, 2999, k);
      @(posedge clk_sys);
   endtask
   task automatic quiet(input int i, input int n);
      int p;
      @(posedge clk_sys);
      p = npl[i];
      repeat (n) @(posedge clk_sys);
      rng("irq count", p, p, npl[i]);
   endtask
   // Immediate load, then a deferred value, then immediate again.
   task automatic per(input int i, input logic [7:0] a, input int u);
      wr(a, 8'h81);
      wpulse(i);
      expi(i, 2 * u, 2 * u);
      wr(a, 8'h03);
      expi(i, 4 * u, 4 * u);
      wpulse(i);
      wpulse(i);
      wr(a, 8'h81);
      expi(i, u, 3 * u);
      wpulse(i);
   endtask
   task automatic wdcmd(input logic [7:0] arm, input logic [7:0] c);
      wr(stw_pkg::ADDR_WDCTL, arm | c);
      wr(stw_pkg::ADDR_WDCTL, c);
   endtask
   task automatic wdexp(input int c);
      int k;
      wdcmd(8'h80, 8'(c));
      k = 0;
      do begin @(negedge clk_sys); k++; end while (watchdog_irq !== 1'b1 && k < 200);
      rng("watchdog expiry", (c + 1) * 8 - 1, (c + 2) * 8 + 2, k);
   endtask
   task automatic rstlen(input int lim);
      int k;
      k = 0;
      while (sys_reset_out !== 1'b1 && k < 100) begin @(negedge clk_sys); k++; end
      rng("reset start", 0, lim, k);
      k = 0;
      while (sys_reset_out === 1'b1 && k < 100) begin @(negedge clk_sys); k++; end
      rng("reset length", stw_pkg::RST_HOLD_CYC, stw_pkg::RST_HOLD_CYC, k);
      k = 0;
      while (straps_valid !== 1'b1 && k < 300) begin @(negedge clk_sys); k++; end
      rng("strap delay", stw_pkg::POWERUP_CYC - 1, stw_pkg::POWERUP_CYC + 2, k);
      chk("straps_captured", {5'h00, strap}, {5'h00, straps_captured});
   endtask
   task automatic rdvals();
      rd(stw_pkg::ADDR_SECIRQ, {1'b0, stw_pkg::SEC_RST});
      rd(stw_pkg::ADDR_MSIRQ, {1'b0, stw_pkg::MSI_RST});
      rd(stw_pkg::ADDR_MICROSECOND_RELOAD, stw_pkg::MICROSECOND_RELOAD_RST);
      rd(stw_pkg::ADDR_MSL, stw_pkg::MILLISECOND_RELOAD_VALUE_RST[7:0]);
      rd(stw_pkg::ADDR_MSH, stw_pkg::MILLISECOND_RELOAD_VALUE_RST[15:8]);
      rd(stw_pkg::ADDR_HMS, stw_pkg::HMS_RST);
      rd(stw_pkg::ADDR_WDCTL, {3'b000, stw_pkg::WD_CNT_RST});
   endtask
   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      int seed;
      int p;
      logic [7:0] d;
      logic [7:0] ra[4];
      ra = '{stw_pkg::ADDR_MICROSECOND_RELOAD, stw_pkg::ADDR_MSL, stw_pkg::ADDR_MSH, stw_pkg::ADDR_HMS};
      seed = $urandom(25);
      strap = 3'($urandom);
      repeat (4) @(negedge clk_sys);
      software_reset = 1'b0;
      repeat (3) @(negedge clk_sys);
      rdvals();
      for (int j = 0; j < 4; j++) begin
         d = 8'($urandom);
         wr(ra[j], d);
         rd(ra[j], d);
      end
      d = 8'($urandom);
      wr(stw_pkg::ADDR_EIPRI, d);
      rd(stw_pkg::ADDR_EIPRI, {3'b000, d[4:0]});
      chk("ext_irq_priority", {3'b000, d[4:0]}, {3'b000, ext_irq_priority});
      d = 8'($urandom);
      wr(stw_pkg::ADDR_SECIRQ, d);
      rd(stw_pkg::ADDR_SECIRQ, {1'b0, d[6:0]});
      wr(8'hF6, d);
      rd(8'hF6, 8'h00);
      wr(stw_pkg::ADDR_MSH, 8'h00);
      wr(stw_pkg::ADDR_MSL, 8'h03);
      wr(stw_pkg::ADDR_HMS, 8'h01);
      per(0, stw_pkg::ADDR_MSIRQ, 4);
      per(1, stw_pkg::ADDR_SECIRQ, 8);
      @(negedge clk_sys);
      en_m = 1'b0;
      en_s = 1'b0;
      quiet(0, 40);
      quiet(1, 64);
      @(negedge clk_sys);
      en_m = 1'b1;
      en_s = 1'b1;
      wpulse(0);
      wpulse(1);
      wr(stw_pkg::ADDR_WDCTL, 8'h82);
      quiet(2, 60);
      wdexp(2);
      rd(stw_pkg::ADDR_WDCTL, 8'h02);
      p = npl[2];
      for (int j = 0; j < 6; j++) begin
         wdcmd(8'h20, 8'h02);
         repeat (10) @(negedge clk_sys);
         chk("watchdog_irq", 8'h00, {7'h00, watchdog_irq});
      end
      rng("irq count", p, p, npl[2]);
      wdcmd(8'h40, 8'h02);
      quiet(2, 60);
      @(negedge clk_sys);
      wd_rdis = 1'b0;
      strap = 3'($urandom);
      wdcmd(8'h80, 8'h02);
      rstlen(40);
      rdvals();
      // A reload of 2 held long enough lets the microsecond period check run.
      wr(stw_pkg::ADDR_MICROSECOND_RELOAD, 8'h02);
      wr(stw_pkg::ADDR_SWRST, 8'h01);
      repeat (120) @(negedge clk_sys);
      chk("sys_reset_out", 8'h00, {7'h00, sys_reset_out});
      strap = 3'($urandom);
      wr(stw_pkg::ADDR_SWRST, 8'h00);
      rstlen(3);
      rdvals();
      test_done();
   end
   initial begin
      #200000;
      n_errors++;
      $display("CHECK FAILED run time expected finish seen timeout");
      test_done();
   end
endmodule
